// File: core/acs_clock_select.sv
// sample clock source selection, input lock report and link channel plan
// Overview of operation
// RULE1 - auto mode follows a valid input clock
// RULE2 - lost reference returns to internal master; code moves to the first locked input, internal only when none is locked
// RULE3 - valid preferred input is the reference
// RULE4 - else scan other inputs, take first valid
// RULE5 - no valid input gives internal clock
// RULE6 - forced internal mode ignores all inputs
// RULE7 - each input reports none, lock or sync
// RULE8 - current reference source is readable
// RULE9 - double speed optical ports carry four channels
// RULE10 - quad speed optical ports carry two channels
// RULE11 - madi carries 64, 32, 16 channels
// RULE12 - second optical port may carry aes output
// RULE13 - unlocked source moves to next in list
// RULE14 - source switch without runt clock pulses
// RULE15 - sync means rate matches within tolerance
`timescale 1ns/1ns
`default_nettype none
module acs_clock_select
	import acs_pkg::*;
#(
	parameter int SYNC_WIN_CYC = SYNC_WIN_DEFAULT
)(
	input wire logic MCLK_IN,
	input wire logic RST_N_IN,
	input wire logic [N_SRC-1:0] REF_CLK_IN,
	input wire logic AXI_AWVALID_IN,
	output logic AXI_AWREADY_OUT,
	input wire logic [3:0] AXI_AWADDR_IN,
	input wire logic AXI_WVALID_IN,
	output logic AXI_WREADY_OUT,
	input wire logic [31:0] AXI_WDATA_IN,
	input wire logic [3:0] AXI_WSTRB_IN,
	output logic AXI_BVALID_OUT,
	input wire logic AXI_BREADY_IN,
	output logic [1:0] AXI_BRESP_OUT,
	input wire logic AXI_ARVALID_IN,
	output logic AXI_ARREADY_OUT,
	input wire logic [3:0] AXI_ARADDR_IN,
	output logic AXI_RVALID_OUT,
	input wire logic AXI_RREADY_IN,
	output logic [31:0] AXI_RDATA_OUT,
	output logic [1:0] AXI_RRESP_OUT,
	output logic SAMPLE_CLK_OUT,
	output logic [2:0] CUR_SRC_OUT,
	output logic [6:0] OPT_CHANNELS_OUT,
	output logic [6:0] MADI_CHANNELS_OUT,
	output logic OPT2_TX_FROM_AES_OUT,
	output logic IRQ_OUT
);
	typedef enum logic [1:0] {
		ST_STABLE = 2'b01,
		ST_SWITCH = 2'b10
	} acs_state_t;

	localparam int WIN_W = $clog2(SYNC_WIN_CYC + 1);
	localparam int LK_W = $clog2(LOCK_CYC + 1);

	logic [6:0] ctrl_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic [WIN_W-1:0] win_q;
	logic [9:0] act_cnt_q;
	logic [8:0] int_div_q;
	logic int_lvl_q;
	logic [2:0] cur_src_q;
	logic [2:0] nxt_src_q;
	acs_state_t state_q;
	logic clk_q;
	logic clk_d1_q;
	logic [N_SRC-1:0] lock;
	logic [N_SRC-1:0] sync;
	logic [N_SRC-1:0] lock_d1_q;
	logic [N_SRC-1:0] lvl;
	logic [2*N_SRC-1:0] link_rep;
	logic win_end;
	logic act_tick;

	// per input recovery monitor
	genvar gi;
	generate
		for (gi = 0; gi < N_SRC; gi++)
		begin : g_in
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic [LK_W-1:0] quiet_q;
			logic [9:0] cnt_q;
			logic sync_q;
			logic rise;
			logic [9:0] diff;
			assign rise = s2_q & ~s3_q;
			assign diff = (cnt_q > act_cnt_q) ? cnt_q - act_cnt_q : act_cnt_q - cnt_q;
			always_ff @(posedge MCLK_IN)
			begin
				s1_q <= REF_CLK_IN[gi];
				s2_q <= s1_q;
				s3_q <= s2_q;
				if (!RST_N_IN)
				begin
					quiet_q <= LK_W'(LOCK_CYC);
					cnt_q <= 10'h000;
					sync_q <= 1'b0;
				end
				else
				begin
					// lock while edges arrive inside the timeout
					if (rise)
						quiet_q <= '0;
					else if (quiet_q != LK_W'(LOCK_CYC))
						quiet_q <= quiet_q + 1'b1;
					cnt_q <= win_end ? 10'h000 : cnt_q + {9'h000, rise};
					if (win_end)
						sync_q <= lock[gi] && (diff <= 10'(SYNC_TOL)); // [RULE15]
					else if (!lock[gi])
						sync_q <= 1'b0;
				end
			end
			assign lock[gi] = quiet_q != LK_W'(LOCK_CYC);
			assign sync[gi] = sync_q & lock[gi];
			assign lvl[gi] = s2_q;
			assign link_rep[2*gi +: 2] = sync[gi] ? LNK_SYNC :
				(lock[gi] ? LNK_LOCK : LNK_NONE); // [RULE7]
		end
	endgenerate

	// first locked input in list order, 0 when none
	function automatic logic [2:0] first_lock(input logic [N_SRC-1:0] l);
		logic [2:0] r;
		r = SRC_INT;
		for (int i = N_SRC - 1; i >= 0; i--)
			if (l[i])
				r = 3'(i + 1);
		return r;
	endfunction

	wire force_int = ctrl_q[CTRL_FORCE_INT];
	wire [2:0] pref = ctrl_q[CTRL_PREF_LSB +: 3];
	wire [1:0] speed = ctrl_q[CTRL_SPEED_LSB +: 2];
	wire pref_ok = (pref < 3'(N_SRC)) && lock[pref];
	wire [2:0] target = force_int ? SRC_INT : // [RULE6]
		(pref_ok ? pref + 3'h1 : // [RULE3]
		first_lock(lock)); // [RULE1] [RULE4] [RULE5] [RULE13]
	wire [6:0] all_lvl = {lvl, int_lvl_q};
	wire cur_lvl = all_lvl[cur_src_q];
	wire nxt_lvl = all_lvl[nxt_src_q];
	wire cur_live = (cur_src_q == SRC_INT) || lock[cur_src_q - 3'h1];
	// commit only with the new clock low and the old one low or dead
	wire commit = (state_q == ST_SWITCH) && (!cur_lvl || !cur_live) && !nxt_lvl
		&& (nxt_src_q == target); // [RULE14]
	wire lock_lost = |(lock_d1_q & ~lock);
	assign win_end = win_q == WIN_W'(SYNC_WIN_CYC - 1);
	assign act_tick = clk_q & ~clk_d1_q;

	// internal crystal divider and selection state
	always_ff @(posedge MCLK_IN)
	begin
		if (!RST_N_IN)
		begin
			int_div_q <= 9'h000;
			int_lvl_q <= 1'b0;
			state_q <= ST_STABLE;
			cur_src_q <= SRC_INT;
			nxt_src_q <= SRC_INT;
			clk_q <= 1'b0;
			clk_d1_q <= 1'b0;
			win_q <= '0;
			act_cnt_q <= 10'h000;
			lock_d1_q <= '0;
		end
		else
		begin
			int_div_q <= (int_div_q == 9'(INT_HALF_CYC - 1)) ? 9'h000 : int_div_q + 9'h001;
			if (int_div_q == 9'(INT_HALF_CYC - 1))
				int_lvl_q <= ~int_lvl_q;
			case (state_q)
				ST_STABLE:
				begin
					if (target != cur_src_q) // [RULE2]
					begin
						nxt_src_q <= target;
						state_q <= ST_SWITCH;
					end
				end
				ST_SWITCH:
				begin
					if (commit)
					begin
						cur_src_q <= nxt_src_q;
						state_q <= ST_STABLE;
					end
					else
						nxt_src_q <= target;
				end
				default:
					state_q <= ST_STABLE;
			endcase
			clk_q <= commit ? 1'b0 : cur_lvl; // [RULE14]
			clk_d1_q <= clk_q;
			win_q <= win_end ? '0 : win_q + 1'b1;
			act_cnt_q <= win_end ? 10'h000 : act_cnt_q + {9'h000, act_tick};
			lock_d1_q <= lock;
		end
	end

	assign SAMPLE_CLK_OUT = clk_q;
	assign CUR_SRC_OUT = cur_src_q; // [RULE8]

	// link channel plan per speed range
	always_ff @(posedge MCLK_IN)
	begin
		if (!RST_N_IN)
		begin
			OPT_CHANNELS_OUT <= OPT_CH_SINGLE;
			MADI_CHANNELS_OUT <= MADI_CH_SINGLE;
			OPT2_TX_FROM_AES_OUT <= 1'b0;
		end
		else
		begin
			OPT_CHANNELS_OUT <= (speed == SPD_QUAD) ? OPT_CH_QUAD : // [RULE10]
				(speed == SPD_DOUBLE) ? OPT_CH_DOUBLE : OPT_CH_SINGLE; // [RULE9]
			MADI_CHANNELS_OUT <= (speed == SPD_QUAD) ? MADI_CH_QUAD :
				(speed == SPD_DOUBLE) ? MADI_CH_DOUBLE : MADI_CH_SINGLE; // [RULE11]
			OPT2_TX_FROM_AES_OUT <= ctrl_q[CTRL_OPT2_AES]; // [RULE12]
		end
	end

	// axi4-lite slave
	wire wr_go = AXI_AWVALID_IN & AXI_WVALID_IN & ~AXI_BVALID_OUT;
	wire rd_go = AXI_ARVALID_IN & ~AXI_RVALID_OUT;
	wire wr_ctrl = wr_go && AXI_AWADDR_IN == OFS_CTRL && AXI_WSTRB_IN[0];
	wire wr_istat = wr_go && AXI_AWADDR_IN == OFS_IRQ_STAT && AXI_WSTRB_IN[0];
	wire wr_imask = wr_go && AXI_AWADDR_IN == OFS_IRQ_MASK && AXI_WSTRB_IN[0];
	wire aw_map = AXI_AWADDR_IN[1:0] == 2'h0;
	wire ar_map = AXI_ARADDR_IN[1:0] == 2'h0;
	wire [31:0] status_word = {16'h0000, link_rep, 1'b0, cur_src_q};
	wire [31:0] rd_word =
		(AXI_ARADDR_IN == OFS_CTRL) ? {25'h000_0000, ctrl_q} :
		(AXI_ARADDR_IN == OFS_STATUS) ? status_word :
		(AXI_ARADDR_IN == OFS_IRQ_STAT) ? {30'h0000_0000, irq_stat_q} :
		(AXI_ARADDR_IN == OFS_IRQ_MASK) ? {30'h0000_0000, irq_mask_q} : 32'h0000_0000;
	wire [1:0] irq_set = {lock_lost, commit};
	assign AXI_AWREADY_OUT = wr_go;
	assign AXI_WREADY_OUT = wr_go;
	assign AXI_ARREADY_OUT = rd_go;

	always_ff @(posedge MCLK_IN)
	begin
		if (!RST_N_IN)
		begin
			ctrl_q <= CTRL_RESET;
			irq_stat_q <= 2'h0;
			irq_mask_q <= 2'h0;
			AXI_BVALID_OUT <= 1'b0;
			AXI_BRESP_OUT <= 2'h0;
			AXI_RVALID_OUT <= 1'b0;
			AXI_RDATA_OUT <= 32'h0000_0000;
			AXI_RRESP_OUT <= 2'h0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= AXI_WDATA_IN[6:0];
			if (wr_imask)
				irq_mask_q <= AXI_WDATA_IN[1:0];
			// set wins over write-one clear
			irq_stat_q <= (irq_stat_q & ~(wr_istat ? AXI_WDATA_IN[1:0] : 2'h0)) | irq_set;
			if (wr_go)
			begin
				AXI_BVALID_OUT <= 1'b1;
				AXI_BRESP_OUT <= aw_map ? 2'h0 : 2'h2;
			end
			else if (AXI_BREADY_IN)
				AXI_BVALID_OUT <= 1'b0;
			if (rd_go)
			begin
				AXI_RVALID_OUT <= 1'b1;
				AXI_RDATA_OUT <= rd_word;
				AXI_RRESP_OUT <= ar_map ? 2'h0 : 2'h2;
			end
			else if (AXI_RREADY_IN)
				AXI_RVALID_OUT <= 1'b0;
		end
	end

	assign IRQ_OUT = |(irq_stat_q & irq_mask_q);

	// run lengths of a dead reference and of an unused valid preference
	logic [11:0] dead_cnt_q;
	logic [11:0] pref_cnt_q;
	wire dead_ref = cur_src_q != SRC_INT && !cur_live && !force_int;
	wire pref_wait = !force_int && pref_ok && cur_src_q != pref + 3'h1;
	always_ff @(posedge MCLK_IN)
	begin
		if (!RST_N_IN)
		begin
			dead_cnt_q <= 12'h000;
			pref_cnt_q <= 12'h000;
		end
		else
		begin
			dead_cnt_q <= dead_ref ? dead_cnt_q + 12'h001 : 12'h000;
			pref_cnt_q <= pref_wait ? pref_cnt_q + 12'h001 : 12'h000;
		end
	end

	// checks
	chk_forced_internal: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [RULE6]
		$rose(force_int) |-> ##[1:600] cur_src_q == SRC_INT)
		else $error("forced internal mode not reached");
	chk_none_internal: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [RULE5]
		(lock == '0) [*4] |-> ##[0:600] cur_src_q == SRC_INT)
		else $error("no valid input but not internal");
	chk_lost_leaves: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [RULE2]
		dead_cnt_q < 12'(STUCK_MAX_CYC))
		else $error("dead reference kept");
	chk_pref_taken: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [RULE3]
		pref_cnt_q < 12'(STUCK_MAX_CYC))
		else $error("valid preferred input not used");
	chk_switch_low: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [RULE14]
		$changed(cur_src_q) |-> !clk_q ##1 (clk_q == $past(nxt_lvl) || !clk_q))
		else $error("source switched with clock high");
	chk_sync_lock: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [RULE7]
		(sync & ~$past(sync) & ~$past(lock)) == '0)
		else $error("sync reported without lock");
	chk_sync_window: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [RULE15]
		(sync & ~$past(sync)) != '0 |-> $past(win_end))
		else $error("sync granted outside a window end");
	chk_opt_quad: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [RULE10]
		speed == SPD_QUAD |=> OPT_CHANNELS_OUT == 7'h02 && MADI_CHANNELS_OUT == 7'h10)
		else $error("quad speed channel count wrong");
	chk_opt_double: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [RULE9]
		speed == SPD_DOUBLE |=> OPT_CHANNELS_OUT == 7'h04 && MADI_CHANNELS_OUT == 7'h20)
		else $error("double speed channel count wrong");
	chk_irq_source: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [RULE8]
		commit |=> irq_stat_q[IRQ_SRC_CHG] && cur_src_q == $past(nxt_src_q))
		else $error("source change not flagged");
	cov_follow_input: cover property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		$past(cur_src_q) == SRC_INT && cur_src_q != SRC_INT);
	cov_fall_back: cover property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		$past(cur_src_q) != SRC_INT && cur_src_q == SRC_INT);
	cov_sync_seen: cover property (@(posedge MCLK_IN) disable iff (!RST_N_IN) |sync);
endmodule // acs_clock_select
`default_nettype wire

// File: shared/acs_pkg.sv
// constants for the sample clock source selector
`default_nettype none
package acs_pkg;
	// register byte offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
	localparam logic [3:0] OFS_IRQ_MASK = 4'hC;
	// control fields
	localparam int CTRL_FORCE_INT = 0;
	localparam int CTRL_PREF_LSB = 1;
	localparam int CTRL_SPEED_LSB = 4;
	localparam int CTRL_OPT2_AES = 6;
	localparam logic [6:0] CTRL_RESET = 7'h00;
	// status fields
	localparam int STAT_LINK_LSB = 4;
	localparam int IRQ_SRC_CHG = 0;
	localparam int IRQ_LOCK_LOST = 1;
	// sources: 0 internal, 1..6 word, aes, optical 1, optical 2, madi optical, madi coax
	localparam int N_SRC = 6;
	localparam logic [2:0] SRC_INT = 3'h0;
	// per input report codes
	localparam logic [1:0] LNK_NONE = 2'h0;
	localparam logic [1:0] LNK_LOCK = 2'h1;
	localparam logic [1:0] LNK_SYNC = 2'h2;
	// speed ranges
	localparam logic [1:0] SPD_SINGLE = 2'h0;
	localparam logic [1:0] SPD_DOUBLE = 2'h1;
	localparam logic [1:0] SPD_QUAD = 2'h2;
	localparam logic [6:0] OPT_CH_SINGLE = 7'h08;
	localparam logic [6:0] OPT_CH_DOUBLE = 7'h04;
	localparam logic [6:0] OPT_CH_QUAD = 7'h02;
	localparam logic [6:0] MADI_CH_SINGLE = 7'h40;
	localparam logic [6:0] MADI_CH_DOUBLE = 7'h20;
	localparam logic [6:0] MADI_CH_QUAD = 7'h10;
	// timing
	localparam int CLK_NS = 40;
	localparam int LOCK_TIMEOUT_NS = 100000;
	localparam int LOCK_CYC = LOCK_TIMEOUT_NS / CLK_NS;
	localparam int INT_HALF_CYC = 260;
	localparam int SYNC_TOL = 1;
	localparam int SYNC_WIN_DEFAULT = 16384;
	localparam int STUCK_MAX_CYC = 3000;
endpackage
`default_nettype wire

// File: verification/acs_ref_model.sv
// behavioural far-side audio sources feeding the recovered clock inputs
`timescale 1ns/1ns
`default_nettype none
module acs_ref_model
#(
	parameter int HALF_NS = 160
)(
	input wire logic [5:0] EN_IN,
	output logic [5:0] REF_CLK_OUT
);
	logic ph;
	initial
	begin
		ph = 1'h0;
		#13;
		forever #HALF_NS ph = ~ph;
	end
	// a silent source holds its line still and low
	assign REF_CLK_OUT = EN_IN & {6{ph}};
endmodule // acs_ref_model
`default_nettype wire

// File: verification/audio_clock_source_select_tb_top.sv
// self-checking bench for the sample clock source selector
`timescale 1ns/1ns
`default_nettype none
`define CHK(e, s, nm) begin n_compared++; if ((s) !== (e)) begin failures++; \
	$display("mismatch %s exp %0h got %0h", nm, e, s); end end
module audio_clock_source_select_tb_top import acs_pkg::*;;
	logic clk, rst_n, awv, wv, bready, arv, rready;
	logic [3:0] awa, ara, ws;
	logic [31:0] wd, rd;
	logic [1:0] rsp;
	logic [5:0] en;
	wire logic [5:0] ref_clk;
	wire logic awready, wready, bvalid, arready, rvalid, sclk, opt2, irq;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [2:0] cur;
	wire logic [6:0] optc, madic;
	int failures, n_compared;
	localparam int REF_PER = 320 / CLK_NS;
	logic [6:0] oe [3] = '{OPT_CH_SINGLE, OPT_CH_DOUBLE, OPT_CH_QUAD};
	logic [6:0] me [3] = '{MADI_CH_SINGLE, MADI_CH_DOUBLE, MADI_CH_QUAD};
	acs_ref_model srcs (.EN_IN(en), .REF_CLK_OUT(ref_clk));
	acs_clock_select #(.SYNC_WIN_CYC(2048)) dut (.MCLK_IN(clk), .RST_N_IN(rst_n),
		.REF_CLK_IN(ref_clk), .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awready),
		.AXI_AWADDR_IN(awa), .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wready),
		.AXI_WDATA_IN(wd), .AXI_WSTRB_IN(ws), .AXI_BVALID_OUT(bvalid),
		.AXI_BREADY_IN(bready), .AXI_BRESP_OUT(bresp), .AXI_ARVALID_IN(arv),
		.AXI_ARREADY_OUT(arready), .AXI_ARADDR_IN(ara), .AXI_RVALID_OUT(rvalid),
		.AXI_RREADY_IN(rready), .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp),
		.SAMPLE_CLK_OUT(sclk), .CUR_SRC_OUT(cur), .OPT_CHANNELS_OUT(optc),
		.MADI_CHANNELS_OUT(madic), .OPT2_TX_FROM_AES_OUT(opt2), .IRQ_OUT(irq));
	initial
	begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		awv <= 1'h1; wv <= 1'h1; awa <= a; wd <= d; ws <= 4'hF; bready <= 1'h1;
		do @(posedge clk); while (awready !== 1'h1);
		awv <= 1'h0; wv <= 1'h0;
		do @(posedge clk); while (bvalid !== 1'h1);
		rsp = bresp; bready <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rdr(input logic [3:0] a);
		arv <= 1'h1; ara <= a; rready <= 1'h1;
		do @(posedge clk); while (arready !== 1'h1);
		arv <= 1'h0;
		do @(posedge clk); while (rvalid !== 1'h1);
		rd = rdata; rsp = rresp; rready <= 1'h0;
		@(posedge clk);
	endtask
	// bounded wait for a reference change, then compare
	task automatic wsrc(input logic [2:0] e);
		int n;
		for (n = 0; n < 4000 && cur !== e; n++) @(posedge clk);
		`CHK(e, cur, "cur_src")
	endtask
	// count sample clock rising edges over a span of cycles
	task automatic rises(input int cyc, output int k);
		logic p;
		p = sclk;
		k = 0;
		repeat (cyc)
		begin
			@(posedge clk);
			if (sclk === 1'h1 && p === 1'h0)
				k++;
			p = sclk;
		end
	endtask
	task automatic t_reset;
		`CHK(OPT_CH_SINGLE, optc, "opt_ch")
		`CHK(MADI_CH_SINGLE, madic, "madi_ch")
		`CHK(1'h0, irq, "irq")
		rdr(OFS_CTRL);
		`CHK(32'h0000_0000, rd, "ctrl")
		rdr(OFS_STATUS);
		`CHK(32'h0000_0000, rd, "status")
		$display("done reset");
	endtask
	task automatic t_auto;
		int k;
		en <= 6'h02;
		wsrc(3'h2);
		repeat (4400) @(posedge clk);
		rdr(OFS_STATUS);
		`CHK(3'h2, rd[2:0], "status_src")
		`CHK(LNK_SYNC, rd[7:6], "aes_state")
		`CHK(LNK_NONE, rd[5:4], "word_state")
		rises(50 * REF_PER, k);
		`CHK(50, k, "aes_clk_edges")
		$display("done auto");
	endtask
	task automatic t_pref;
		en <= 6'h07;
		wr(OFS_CTRL, 32'h0000_0004);
		wsrc(3'h3);
		en <= 6'h03;
		wsrc(3'h1);
		rdr(OFS_STATUS);
		`CHK(LNK_NONE, rd[9:8], "opt1_state")
		$display("done preferred");
	endtask
	task automatic t_force;
		wr(OFS_CTRL, 32'h0000_0001);
		wsrc(3'h0);
		wr(OFS_CTRL, 32'h0000_000E);
		wsrc(3'h1);
		en <= 6'h00;
		wsrc(3'h0);
		$display("done force");
	endtask
	task automatic t_irq;
		int k;
		repeat (10) @(posedge clk);
		wr(OFS_IRQ_MASK, 32'h0000_0003);
		`CHK(1'h1, irq, "irq_on")
		wr(OFS_IRQ_MASK, 32'h0000_0000);
		`CHK(1'h0, irq, "irq_masked")
		wr(OFS_IRQ_MASK, 32'h0000_0003);
		wr(OFS_IRQ_STAT, 32'h0000_0003);
		rdr(OFS_IRQ_STAT);
		`CHK(32'h0000_0000, rd, "irq_stat")
		`CHK(1'h0, irq, "irq_cleared")
		wr(4'h2, 32'h0000_0001);
		`CHK(2'h2, rsp, "bad_wr_resp")
		rdr(4'h1);
		`CHK(2'h2, rsp, "bad_rd_resp")
		rises(4 * INT_HALF_CYC, k);
		`CHK(2, k, "int_clk_edges")
		$display("done irq");
	endtask
	task automatic t_speed;
		for (int i = 0; i < 3; i++)
		begin
			wr(OFS_CTRL, 32'(i << CTRL_SPEED_LSB) | (i == 1 ? 32'h0000_0041 : 32'h0000_0001));
			repeat (3) @(posedge clk);
			`CHK(oe[i], optc, "opt_ch")
			`CHK(me[i], madic, "madi_ch")
			`CHK(1'(i == 1), opt2, "opt2_aes")
		end
		$display("done speed");
	endtask
	task automatic t_rerun;
		rst_n <= 1'h0;
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		`CHK(OPT_CH_SINGLE, optc, "opt_ch_rst")
		`CHK(3'h0, cur, "cur_rst")
		rdr(OFS_CTRL);
		`CHK(32'h0000_0000, rd, "ctrl_rst")
		$display("done rerun");
	endtask
	task summarize;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		rst_n = 1'h0; awv = 1'h0; wv = 1'h0; bready = 1'h0; arv = 1'h0; rready = 1'h0;
		awa = 4'h0; ara = 4'h0; ws = 4'h0; wd = 32'h0000_0000; en = 6'h00;
		failures = 0;
		n_compared = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		t_reset;
		t_auto;
		t_pref;
		t_force;
		t_irq;
		t_speed;
		t_rerun;
		summarize;
	end
	// hang guard, well beyond the expected run
	initial
	begin
		repeat (60000) @(posedge clk);
		failures++;
		summarize;
	end
endmodule // audio_clock_source_select_tb_top
`default_nettype wire
